// File: pmt_timer.sv
// Eight-bit period match timer with prescaler, postscaler, match flag and interrupt
// Assumes ref_clk is the oscillator clock; the instruction tick is ref_clk divided by four
//
// Function
// - count on instruction clock through prescaler
// - prescale select 00=1, 01=4, 1x=16
// - count from zero, compare with period
// - on match, zero next tick, advance postscaler
// - postscale ratio is field value plus one
// - postscaler output sets match interrupt flag
// - count and period readable and writable anytime
// - reset loads count zero, period all ones
// - timer-on bit enables or halts counting
// - count or control write, reset clear scalers
// - control write leaves count unchanged
// - control bit 7 reads zero, reset zero
`timescale 1ns/1ps
`include "pmt_defs.svh"

module pmt_timer (
  input wire logic ref_clk, // Oscillator clock, 25 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire pmt_pkg::pmt_addr_t regAddr, // Register address
  input wire pmt_pkg::pmt_byte_t regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output pmt_pkg::pmt_byte_t regRdata, // Read data, one cycle after strobe
  output logic irqOut // Level interrupt
);
  import pmt_pkg::*;

  // ********************************************
  // Register decode
  // ********************************************
  function automatic logic isWr(input pmt_addr_t a, input pmt_addr_t off, input logic wr);
    return wr && (a == off);
  endfunction : isWr

  logic wrCtrl;
  logic wrPeriod;
  logic wrCount;
  logic wrIrqEn;
  logic wrIrqClr;
  assign wrCtrl = isWr(regAddr, `PMT_OFF_CONTROL, regWr);
  assign wrPeriod = isWr(regAddr, `PMT_OFF_PERIOD, regWr);
  assign wrCount = isWr(regAddr, `PMT_OFF_COUNT, regWr);
  assign wrIrqEn = isWr(regAddr, `PMT_OFF_IRQ_ENABLE, regWr);
  assign wrIrqClr = isWr(regAddr, `PMT_OFF_IRQ_CLEAR, regWr);

  // ********************************************
  // Registers
  // ********************************************
  pmt_byte_t control_ff;
  pmt_byte_t period_ff;
  pmt_byte_t count_ff;
  logic irqFlag_ff;
  logic irqEn_ff;
  logic [1:0] instrDiv_ff;
  logic [3:0] preCnt_ff;
  logic [3:0] postCnt_ff;
  logic scalerClr;
  logic timerOn;
  pmt_pre_t preSel;
  logic [3:0] preMax;
  logic instrTick;
  logic preTick;
  logic match;
  logic postTick;

  assign scalerClr = wrCount || wrCtrl;
  assign timerOn = control_ff[`PMT_CTRL_ON_BIT];
  assign preSel = pmt_pre_t'(control_ff[`PMT_CTRL_PRE_MSB:`PMT_CTRL_PRE_LSB]);
  always_comb begin
    case (preSel)
      PMT_PRE_DIV1: preMax = `PMT_PRE_MAX_1;
      PMT_PRE_DIV4: preMax = `PMT_PRE_MAX_4;
      default: preMax = `PMT_PRE_MAX_16;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      control_ff <= `PMT_RST_CONTROL;
    end else if (wrCtrl) begin
      control_ff <= regWdata & `PMT_CTRL_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      period_ff <= `PMT_RST_PERIOD;
    end else if (wrPeriod) begin
      period_ff <= regWdata;
    end
  end

  // ********************************************
  // Instruction clock and prescaler
  // ********************************************
  // Free-running divide by four gives the instruction tick
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      instrDiv_ff <= 2'h0;
    end else begin
      instrDiv_ff <= instrDiv_ff + 2'h1;
    end
  end
  assign instrTick = (instrDiv_ff == `PMT_INSTR_DIV);

  assign preTick = timerOn && instrTick && (preCnt_ff >= preMax);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || scalerClr) begin
      preCnt_ff <= 4'h0;
    end else if (timerOn && instrTick) begin
      preCnt_ff <= (preCnt_ff >= preMax) ? 4'h0 : preCnt_ff + 4'h1;
    end
  end

  // ********************************************
  // Count, match and postscaler
  // ********************************************
  assign match = (count_ff == period_ff);
  assign postTick = preTick && match && (postCnt_ff == control_ff[`PMT_CTRL_POST_MSB:`PMT_CTRL_POST_LSB]);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_ff <= `PMT_RST_COUNT;
    end else if (wrCount) begin
      count_ff <= regWdata;
    end else if (preTick) begin
      count_ff <= match ? 8'h00 : count_ff + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || scalerClr) begin
      postCnt_ff <= 4'h0;
    end else if (preTick && match) begin
      postCnt_ff <= postTick ? 4'h0 : postCnt_ff + 4'h1;
    end
  end

  // ********************************************
  // Interrupt
  // ********************************************
  // A postscaler output in the clearing cycle keeps the flag set
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irqFlag_ff <= 1'b0;
    end else if (postTick) begin
      irqFlag_ff <= 1'b1;
    end else if (wrIrqClr && regWdata[0]) begin
      irqFlag_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irqEn_ff <= 1'b0;
    end else if (wrIrqEn) begin
      irqEn_ff <= regWdata[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= irqFlag_ff && irqEn_ff;
    end
  end

  // ********************************************
  // Read port
  // ********************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `PMT_OFF_CONTROL: regRdata <= control_ff;
        `PMT_OFF_PERIOD: regRdata <= period_ff;
        `PMT_OFF_COUNT: regRdata <= count_ff;
        `PMT_OFF_IRQ_STATUS: regRdata <= {7'h00, irqFlag_ff};
        `PMT_OFF_IRQ_ENABLE: regRdata <= {7'h00, irqEn_ff};
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ********************************************
  // Check helpers
  // ********************************************
  // Spacing of prescaled ticks, less one, for each prescale code
  function automatic logic [7:0] gapFor(input pmt_pre_t sel);
    case (sel)
      PMT_PRE_DIV1: return `PMT_GAP_DIV1;
      PMT_PRE_DIV4: return `PMT_GAP_DIV4;
      default: return `PMT_GAP_DIV16;
    endcase
  endfunction : gapFor

  logic [7:0] chkGap_ff;
  logic chkGapValid_ff;
  logic [4:0] chkMatches_ff;
  logic [3:0] postSel;
  assign postSel = control_ff[`PMT_CTRL_POST_MSB:`PMT_CTRL_POST_LSB];

  // Cycles since the last prescaled tick, saturating
  always_ff @(posedge ref_clk) begin
    if (!rst_n || preTick) begin
      chkGap_ff <= 8'h00;
    end else if (chkGap_ff != 8'hff) begin
      chkGap_ff <= chkGap_ff + 8'h01;
    end
  end

  // A gap is only measured between two ticks with no clear or halt between them
  always_ff @(posedge ref_clk) begin
    if (!rst_n || scalerClr || !timerOn) begin
      chkGapValid_ff <= 1'b0;
    end else if (preTick) begin
      chkGapValid_ff <= 1'b1;
    end
  end

  // Matches seen since the last postscaler output
  always_ff @(posedge ref_clk) begin
    if (!rst_n || scalerClr || postTick) begin
      chkMatches_ff <= 5'h00;
    end else if (preTick && match && chkMatches_ff != 5'h1f) begin
      chkMatches_ff <= chkMatches_ff + 5'h01;
    end
  end

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  instr_tick_rate_a: assert property (instrTick |=> !instrTick [*3] ##1 instrTick)
    else $error("instruction tick not every fourth cycle");
  pre_div1_a: assert property (timerOn && instrTick && preSel == PMT_PRE_DIV1 |-> preTick)
    else $error("divide by one missed a tick");
  pre_div4_a: assert property (preTick && preSel == PMT_PRE_DIV4 && !$changed(control_ff) |=> !preTick [*8])
    else $error("divide by four ticks too soon");
  count_incr_a: assert property (preTick && !match && !wrCount |=> count_ff == $past(count_ff) + 8'h01)
    else $error("count did not advance");
  match_wrap_a: assert property (preTick && match && !wrCount |=> count_ff == 8'h00)
    else $error("count did not wrap on match");
  post_ratio_a: assert property (postTick |-> chkMatches_ff == {1'b0, postSel})
    else $error("postscaler ratio wrong");
  flag_set_a: assert property (postTick |=> irqFlag_ff)
    else $error("flag not set by postscaler");
  count_write_a: assert property (wrCount |=> count_ff == $past(regWdata) && preCnt_ff == 4'h0)
    else $error("count write lost");
  halt_hold_a: assert property (!timerOn && !regWr |=> $stable(count_ff) && $stable(postCnt_ff))
    else $error("halted timer moved");
  ctrl_keep_a: assert property (wrCtrl && !preTick |=> $stable(count_ff) && postCnt_ff == 4'h0)
    else $error("control write disturbed count");
  bit7_zero_a: assert property (control_ff[7] == 1'b0)
    else $error("control bit 7 set");
  irq_gate_a: assert property (irqOut == $past(irqFlag_ff && irqEn_ff))
    else $error("interrupt not gated by enable");
  flag_sticky_a: assert property (irqFlag_ff && !(wrIrqClr && regWdata[0]) |=> irqFlag_ff)
    else $error("flag dropped without clear");
  halt_pre_a: assert property (!timerOn |-> !preTick)
    else $error("prescaler ticked while halted");

  tick_gap_a: assert property (preTick && chkGapValid_ff |-> chkGap_ff == gapFor(preSel))
    else $error("prescaled tick spacing wrong");
  post_due_a: assert property (preTick && match && chkMatches_ff == {1'b0, postSel} |-> postTick)
    else $error("postscaler output missed");
  count_hold_a: assert property (!preTick && !wrCount |=> $stable(count_ff))
    else $error("count moved without a tick");
  post_hold_a: assert property (!(preTick && match) && !scalerClr |=> $stable(postCnt_ff))
    else $error("postscaler moved without a match");
  flag_cause_a: assert property (!irqFlag_ff && !postTick |=> !irqFlag_ff)
    else $error("flag set without postscaler output");
  period_write_a: assert property (wrPeriod |=> period_ff == $past(regWdata))
    else $error("period write lost");
  period_hold_a: assert property (!wrPeriod |=> $stable(period_ff))
    else $error("period changed without a write");
  read_count_a: assert property (regRd && regAddr == `PMT_OFF_COUNT |=> regRdata == $past(count_ff))
    else $error("count read wrong");
  read_period_a: assert property (regRd && regAddr == `PMT_OFF_PERIOD |=> regRdata == $past(period_ff))
    else $error("period read wrong");
  read_idle_a: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data outside read cycle");
  count_clear_a: assert property (wrCount |=> postCnt_ff == 4'h0)
    else $error("count write kept postscaler");
  ctrl_clear_a: assert property (wrCtrl |=> preCnt_ff == 4'h0 && postCnt_ff == 4'h0)
    else $error("control write kept scalers");
  ctrl_write_a: assert property (wrCtrl |=> control_ff == ($past(regWdata) & `PMT_CTRL_MASK))
    else $error("control write lost");
  ctrl_hold_a: assert property (!wrCtrl |=> $stable(control_ff))
    else $error("control changed without a write");
  read_ctrl_a: assert property (regRd && regAddr == `PMT_OFF_CONTROL |=> regRdata == $past(control_ff))
    else $error("control read wrong");
  read_status_a: assert property (regRd && regAddr == `PMT_OFF_IRQ_STATUS |=>
    regRdata == {7'h00, $past(irqFlag_ff)})
    else $error("status read wrong");
  read_enable_a: assert property (regRd && regAddr == `PMT_OFF_IRQ_ENABLE |=>
    regRdata == {7'h00, $past(irqEn_ff)})
    else $error("enable read wrong");
  read_clear_a: assert property (regRd && regAddr >= `PMT_OFF_IRQ_CLEAR |=> regRdata == 8'h00)
    else $error("write-only or unmapped read not zero");
  flag_clear_a: assert property (wrIrqClr && regWdata[0] && !postTick |=> !irqFlag_ff)
    else $error("flag not cleared");
  enable_write_a: assert property (wrIrqEn |=> irqEn_ff == $past(regWdata[0]))
    else $error("enable write lost");
  irq_low_a: assert property (!irqEn_ff |=> !irqOut)
    else $error("interrupt raised while disabled");
  halt_pre_cnt_a: assert property (!timerOn && !regWr |=> $stable(preCnt_ff))
    else $error("halted prescaler moved");

  // ********************************************
  // Reset checks
  // ********************************************
  // These run while reset is held, so the default disable is overridden
  reset_regs_a: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rst_n |=> count_ff == `PMT_RST_COUNT && period_ff == `PMT_RST_PERIOD)
    else $error("reset values not loaded");
  reset_scaler_a: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rst_n |=> preCnt_ff == 4'h0 && postCnt_ff == 4'h0)
    else $error("reset kept scalers");
  reset_ctrl_a: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rst_n |=> control_ff == `PMT_RST_CONTROL)
    else $error("control not zero after reset");
  reset_irq_a: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rst_n |=> !irqFlag_ff && !irqEn_ff && !irqOut && regRdata == 8'h00)
    else $error("interrupt or read data set after reset");

  wrap_c: cover property (preTick && match);
  post_c: cover property (postTick && control_ff[6:3] == 4'hf);
  irq_c: cover property (irqOut);
  div16_c: cover property (preTick && preSel == PMT_PRE_DIV16B);
  ctrl_run_c: cover property (wrCtrl && timerOn);
endmodule : pmt_timer

// File: pmt_defs.svh
// Register offsets, field positions, reset values and timing figures of the period match timer
// Assumes a plain register port with byte-wide data in the low bits
`ifndef PMT_DEFS_SVH
`define PMT_DEFS_SVH

`define PMT_OFF_CONTROL 4'h0
`define PMT_OFF_PERIOD 4'h1
`define PMT_OFF_COUNT 4'h2
`define PMT_OFF_IRQ_STATUS 4'h3
`define PMT_OFF_IRQ_ENABLE 4'h4
`define PMT_OFF_IRQ_CLEAR 4'h5

`define PMT_CTRL_PRE_LSB 0
`define PMT_CTRL_PRE_MSB 1
`define PMT_CTRL_ON_BIT 2
`define PMT_CTRL_POST_LSB 3
`define PMT_CTRL_POST_MSB 6
`define PMT_CTRL_MASK 8'h7f

`define PMT_RST_CONTROL 8'h00
`define PMT_RST_PERIOD 8'hff
`define PMT_RST_COUNT 8'h00

`define PMT_INSTR_DIV 2'h3
`define PMT_PRE_MAX_1 4'h0
`define PMT_PRE_MAX_4 4'h3
`define PMT_PRE_MAX_16 4'hf

`define PMT_GAP_DIV1 8'h03
`define PMT_GAP_DIV4 8'h0f
`define PMT_GAP_DIV16 8'h3f

`endif

// File: pmt_pkg.sv
// Types shared by the period match timer
// Assumes pmt_defs.svh is compiled alongside
package pmt_pkg;
  typedef logic [7:0] pmt_byte_t;
  typedef logic [3:0] pmt_addr_t;
  typedef enum logic [1:0] {PMT_PRE_DIV1, PMT_PRE_DIV4, PMT_PRE_DIV16A, PMT_PRE_DIV16B} pmt_pre_t;
endpackage : pmt_pkg

// File: pmt_timer_bench.sv
// Self-checking bench of the period match timer
// Assumes pmt_defs.svh offsets and a 25 MHz oscillator clock on ref_clk
`timescale 1ns/1ps
`include "pmt_defs.svh"

module pmt_timer_bench;
  import pmt_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  pmt_addr_t regAddr = 4'h0;
  pmt_byte_t regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  pmt_byte_t regRdata;
  logic irqOut;
  logic rdPend = 1'b0;
  pmt_byte_t expQ[$];
  int n_errors = 0;
  int compares = 0;
  logic [31:0] seed = 32'h617c12b0;

  pmt_timer i_pmt_timer (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irqOut(irqOut));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // ************************************
  // Bus tasks and checking
  // ************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic check(input pmt_byte_t e, input pmt_byte_t g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : check

  task automatic stop_test;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rdPend) begin
      check(expQ.pop_front(), regRdata);
    end
    rdPend <= regRd;
  end

  task automatic wr(input pmt_addr_t a, input pmt_byte_t d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input pmt_addr_t a, input pmt_byte_t e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    expQ.push_back(e);
    @(posedge ref_clk);
    regRd <= 1'b0;
  endtask : rd

  task automatic irqIs(input logic e);
    repeat (3) @(posedge ref_clk);
    check({7'h00, e}, {7'h00, irqOut});
  endtask : irqIs

  // Cycles from the control write to the interrupt, with slack for the free-running tick phase
  task automatic runMatch(input logic [1:0] pre, input logic [3:0] post, input pmt_byte_t per);
    int n;
    int e;
    e = 4 * (pre[1] ? 16 : (pre[0] ? 4 : 1)) * (int'(per) + 1) * (int'(post) + 1);
    wr(`PMT_OFF_CONTROL, 8'h00);
    wr(`PMT_OFF_PERIOD, per);
    wr(`PMT_OFF_COUNT, 8'h00);
    wr(`PMT_OFF_IRQ_CLEAR, 8'h01);
    wr(`PMT_OFF_IRQ_ENABLE, 8'h01);
    wr(`PMT_OFF_CONTROL, {1'b0, post, 1'b1, pre});
    for (n = 0; n < 20000 && irqOut !== 1'b1; n++) begin
      @(posedge ref_clk);
    end
    check(8'h01, {7'h00, (n >= e - 4) && (n <= e + 6)});
    if (n >= 20000) begin
      stop_test();
    end
  endtask : runMatch

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    logic [3:0] posts[4];
    pmt_byte_t pers[4];
    posts = '{4'h0, 4'h5, 4'h1, 4'hf};
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`PMT_OFF_CONTROL, `PMT_RST_CONTROL);
    rd(`PMT_OFF_PERIOD, `PMT_RST_PERIOD);
    rd(`PMT_OFF_COUNT, `PMT_RST_COUNT);
    rd(`PMT_OFF_IRQ_STATUS, 8'h00);
    rd(4'hc, 8'h00);
    wr(`PMT_OFF_CONTROL, 8'hfb);
    rd(`PMT_OFF_CONTROL, 8'h7b);
    seed = xs(seed);
    wr(`PMT_OFF_PERIOD, seed[7:0]);
    rd(`PMT_OFF_PERIOD, seed[7:0]);
    wr(`PMT_OFF_COUNT, seed[15:8]);
    repeat (200) @(posedge ref_clk);
    rd(`PMT_OFF_COUNT, seed[15:8]);
    wr(`PMT_OFF_CONTROL, 8'h30);
    rd(`PMT_OFF_COUNT, seed[15:8]);
    pers = '{8'h00, {4'h0, seed[19:16]}, {4'h0, seed[23:20]}, 8'h03};
    for (int i = 0; i < 4; i++) begin
      runMatch(i[1:0], posts[i], pers[i]);
    end
    wr(`PMT_OFF_CONTROL, 8'h00);
    rd(`PMT_OFF_IRQ_STATUS, 8'h01);
    wr(`PMT_OFF_IRQ_ENABLE, 8'h00);
    irqIs(1'b0);
    wr(`PMT_OFF_IRQ_ENABLE, 8'h01);
    irqIs(1'b1);
    rd(`PMT_OFF_IRQ_ENABLE, 8'h01);
    wr(`PMT_OFF_IRQ_CLEAR, 8'h01);
    irqIs(1'b0);
    rd(`PMT_OFF_IRQ_STATUS, 8'h00);
    // Reset in mid-run with the timer counting
    wr(`PMT_OFF_PERIOD, seed[7:0]);
    wr(`PMT_OFF_CONTROL, 8'h04);
    repeat (40) @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`PMT_OFF_COUNT, `PMT_RST_COUNT);
    rd(`PMT_OFF_PERIOD, `PMT_RST_PERIOD);
    rd(`PMT_OFF_CONTROL, `PMT_RST_CONTROL);
    rd(`PMT_OFF_IRQ_ENABLE, 8'h00);
    repeat (4) @(posedge ref_clk);
    stop_test();
  end
endmodule : pmt_timer_bench
